// ===== core/fqt_query_table.sv
/*
  Query-mode read path of the flash: returns the query structure bytes and
  the per-block lock state byte while query mode is active, array data
  otherwise. Assumes the host read port is synchronous to core_clk and that
  the array controller supplies array data and lock bits on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fqt_cfg.svh"

module fqt_query_table
  import fqt_pkg::*;
#(
  parameter logic [1:0] CAP_SEL = 2'h2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic query_enter,
  input wire logic query_exit,
  input wire logic x8_mode,
  input wire logic rd_req,
  input wire logic [24:0] rd_addr,
  input wire logic [15:0] array_data,
  input wire logic [`FQT_BLOCKS-1:0] block_locked,
  output logic query_active,
  output logic [15:0] rd_data,
  output logic rd_valid
);

  fqt_state_t st_r;
  fqt_state_t st_nxt;
  logic [`FQT_WOFF_W-1:0] woff;
  logic [`FQT_BLK_W-1:0] blk;
  logic lock_sel;
  logic [7:0] q_byte;

  // Region block count low byte by capacity
  function automatic logic [7:0] rgn_y_lo(input logic [1:0] cap);
    case (cap)
      2'h0: rgn_y_lo = `FQT_RGN_Y_32M;
      2'h1: rgn_y_lo = `FQT_RGN_Y_64M;
      2'h2: rgn_y_lo = `FQT_RGN_Y_128M;
      default: rgn_y_lo = `FQT_RGN_Y_256M;
    endcase
  endfunction

  // Query structure byte at a word offset within a block
  function automatic logic [7:0] query_byte(
    input logic [`FQT_WOFF_W-1:0] off,
    input logic lk,
    input logic [1:0] cap
  );
    logic [7:0] b;
    b = 8'h00;
    if (off[15:8] == 8'h00) begin
      case (off[7:0])
        `FQT_OFF_BLK_STATE: b = {7'h00, lk};
        `FQT_OFF_SIG0: b = `FQT_SIG0;
        `FQT_OFF_SIG1: b = `FQT_SIG1;
        `FQT_OFF_SIG2: b = `FQT_SIG2;
        `FQT_OFF_PRI_LO: b = 8'(`FQT_PRI_CODE);
        `FQT_OFF_PRI_HI: b = 8'(`FQT_PRI_CODE >> 8);
        `FQT_OFF_EXT_LO: b = `FQT_EXT_PTR;
        `FQT_OFF_EXT_HI: b = 8'h00;
        `FQT_OFF_ALT_LO: b = 8'h00;
        `FQT_OFF_ALT_HI: b = 8'h00;
        `FQT_OFF_SEC_LO: b = 8'h00;
        `FQT_OFF_SEC_HI: b = 8'h00;
        `FQT_OFF_VLOG_MIN: b = `FQT_VLOG_MIN;
        `FQT_OFF_VLOG_MAX: b = `FQT_VLOG_MAX;
        `FQT_OFF_VPRG_MIN: b = `FQT_VPRG;
        `FQT_OFF_VPRG_MAX: b = `FQT_VPRG;
        `FQT_OFF_WP_TYP: b = `FQT_WP_TYP;
        `FQT_OFF_BW_TYP: b = `FQT_BW_TYP;
        `FQT_OFF_BE_TYP: b = `FQT_BE_TYP;
        `FQT_OFF_CE_TYP: b = `FQT_CE_NONE;
        `FQT_OFF_CE_MAX: b = `FQT_CE_NONE;
        `FQT_OFF_WP_MAX: b = `FQT_MAX_FACTOR;
        `FQT_OFF_BW_MAX: b = `FQT_MAX_FACTOR;
        `FQT_OFF_BE_MAX: b = `FQT_MAX_FACTOR;
        `FQT_OFF_CAP: b = `FQT_CAP_BASE + {6'h00, cap};
        `FQT_OFF_IF_LO: b = `FQT_IF_X8X16;
        `FQT_OFF_IF_HI: b = 8'h00;
        `FQT_OFF_WBUF_LO: b = `FQT_WBUF_EXP;
        `FQT_OFF_WBUF_HI: b = 8'h00;
        `FQT_OFF_REGIONS: b = `FQT_REGION_CNT;
        `FQT_OFF_RGN_B0: b = rgn_y_lo(cap);
        `FQT_OFF_RGN_B1: b = 8'h00;
        `FQT_OFF_RGN_B2: b = 8'h00;
        `FQT_OFF_RGN_B3: b = `FQT_RGN_SIZE_HI;
        default: b = 8'h00;
      endcase
    end
    query_byte = b;
  endfunction

  always_comb begin
    if (x8_mode) begin
      woff = rd_addr[16:1];
      blk = rd_addr[24:17];
    end else begin
      woff = rd_addr[15:0];
      blk = rd_addr[23:16];
    end
  end

  assign lock_sel = block_locked[blk];
  assign q_byte = query_byte(woff, lock_sel, CAP_SEL);

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = rd_req;
    if (query_enter) begin
      st_nxt.mode = FQT_QUERY;
    end else if (query_exit) begin
      st_nxt.mode = FQT_ARRAY;
    end
    if (rd_req) begin
      if (st_r.mode == FQT_QUERY) begin
        st_nxt.data = {8'h00, q_byte};
      end else begin
        st_nxt.data = array_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '{mode: FQT_ARRAY, data: 16'h0000, valid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign query_active = (st_r.mode == FQT_QUERY);
  assign rd_data = st_r.data;
  assign rd_valid = st_r.valid;

  // Checks
  sequence s_qrd(logic [15:0] o);
    query_active && rd_req && woff == o;
  endsequence

  sequence s_done(logic [15:0] v);
    ##1 rd_valid && rd_data == v;
  endsequence

  AST_LOCK: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0002) |=> rd_data == {15'h0000, $past(lock_sel)})
    else $error("lock state byte wrong");

  AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0002) |=> rd_data[7:1] == 7'h00)
    else $error("lock byte reserved bits set");

  AST_SIG: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0010) |-> s_done(16'h0051))
    else $error("signature byte wrong");

  AST_EXT: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0015) |-> s_done(16'h0031))
    else $error("extended pointer wrong");

  AST_VLOG: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001C) |-> s_done(16'h0036))
    else $error("logic supply max wrong");

  AST_BE: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0021) |-> s_done(16'h000A))
    else $error("erase timeout wrong");

  AST_WBUF: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002A) |-> s_done(16'h0005))
    else $error("write buffer exponent wrong");

  AST_RGN: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002C) |-> s_done(16'h0001))
    else $error("region count wrong");

  AST_ENTER: assert property (@(posedge core_clk) disable iff (rst)
    query_enter |=> query_active)
    else $error("query mode not entered");

  AST_ARRAY: assert property (@(posedge core_clk) disable iff (rst)
    !query_active && rd_req |=> rd_data == $past(array_data))
    else $error("array data not returned");

  AST_UPPER: assert property (@(posedge core_clk) disable iff (rst)
    query_active && rd_req |=> rd_data[15:8] == 8'h00)
    else $error("upper byte not zero");

  AST_UNUSED: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0031) |-> s_done(16'h0000))
    else $error("unassigned offset not zero");

  AST_Q03: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0003) |-> s_done(16'h0000))
    else $error("reserved offset not zero");

  AST_QPAGE: assert property (@(posedge core_clk) disable iff (rst)
    query_active && rd_req && woff[15:8] != 8'h00 |=> rd_data == 16'h0000)
    else $error("offset above table not zero");

  AST_Q11: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0011) |-> s_done(16'h0052))
    else $error("signature byte wrong");

  AST_Q12: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0012) |-> s_done(16'h0059))
    else $error("signature byte wrong");

  AST_Q13: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0013) |-> s_done(`FQT_PRI_CODE & 16'h00FF))
    else $error("command set code low byte wrong");

  AST_Q14: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0014) |-> s_done(`FQT_PRI_CODE >> 8))
    else $error("command set code high byte wrong");

  AST_Q16: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0016) |-> s_done(16'h0000))
    else $error("extended pointer high byte wrong");

  AST_Q17: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0017) |-> s_done(16'h0000))
    else $error("alternate set code not zero");

  AST_Q18: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0018) |-> s_done(16'h0000))
    else $error("alternate set code not zero");

  AST_Q19: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0019) |-> s_done(16'h0000))
    else $error("secondary pointer not zero");

  AST_Q1A: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001A) |-> s_done(16'h0000))
    else $error("secondary pointer not zero");

  AST_Q1B: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001B) |-> s_done(16'h0027))
    else $error("logic supply min wrong");

  AST_Q1D: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001D) |-> s_done(16'h0000))
    else $error("programming supply min wrong");

  AST_Q1E: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001E) |-> s_done(16'h0000))
    else $error("programming supply max wrong");

  AST_Q1F: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h001F) |-> s_done(16'h0008))
    else $error("word program timeout wrong");

  AST_Q20: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0020) |-> s_done(16'h0008))
    else $error("buffer write timeout wrong");

  AST_Q22: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0022) |-> s_done(16'h0000))
    else $error("chip erase typical not zero");

  AST_Q26: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0026) |-> s_done(16'h0000))
    else $error("chip erase maximum not zero");

  AST_Q23: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0023) |-> s_done(16'h0004))
    else $error("word program factor wrong");

  AST_Q24: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0024) |-> s_done(16'h0004))
    else $error("buffer write factor wrong");

  AST_Q25: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0025) |-> s_done(16'h0004))
    else $error("block erase factor wrong");

  AST_Q27: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0027) |-> s_done(16'h0016 + {14'h0000, CAP_SEL}))
    else $error("capacity exponent wrong");

  AST_Q28: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0028) |-> s_done(16'h0002))
    else $error("interface code wrong");

  AST_Q29: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0029) |-> s_done(16'h0000))
    else $error("interface code high byte wrong");

  AST_Q2B: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002B) |-> s_done(16'h0000))
    else $error("write buffer high byte wrong");

  AST_Q2D: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002D) |-> s_done((16'h0020 << CAP_SEL) - 16'h0001))
    else $error("region block count wrong");

  AST_Q2E: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002E) |-> s_done(16'h0000))
    else $error("region block count high wrong");

  AST_Q2F: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h002F) |-> s_done(16'h0000))
    else $error("region block size low wrong");

  AST_Q30: assert property (@(posedge core_clk) disable iff (rst)
    s_qrd(16'h0030) |-> s_done(16'h0002))
    else $error("region block size high wrong");

  AST_BYTE: assert property (@(posedge core_clk) disable iff (rst)
    x8_mode && query_active && rd_req && rd_addr[16:0] == 17'h00025
    |=> rd_data == 16'h0059)
    else $error("byte mode address decode wrong");

  AST_EXIT: assert property (@(posedge core_clk) disable iff (rst)
    query_exit && !query_enter |=> !query_active)
    else $error("query mode not left");

  AST_MODE: assert property (@(posedge core_clk) disable iff (rst)
    !query_enter && !query_exit |=> $stable(query_active))
    else $error("mode changed without command");

  AST_VALID: assert property (@(posedge core_clk) disable iff (rst)
    rd_req |=> rd_valid)
    else $error("read not answered");

  AST_NOVLD: assert property (@(posedge core_clk) disable iff (rst)
    !rd_req |=> !rd_valid)
    else $error("answer without read");

  AST_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !rd_req |=> $stable(rd_data))
    else $error("read data changed without read");

endmodule
`default_nettype wire

// ===== core/fqt_cfg.svh
/*
  Offsets, fixed field values and geometry lookups of the flash query table.
  Assumes inclusion by the package and the table module; definitions only.
*/
`ifndef FQT_CFG_SVH
`define FQT_CFG_SVH

// Word offsets inside the query structure
`define FQT_OFF_BLK_STATE 8'h02
`define FQT_OFF_SIG0 8'h10
`define FQT_OFF_SIG1 8'h11
`define FQT_OFF_SIG2 8'h12
`define FQT_OFF_PRI_LO 8'h13
`define FQT_OFF_PRI_HI 8'h14
`define FQT_OFF_EXT_LO 8'h15
`define FQT_OFF_EXT_HI 8'h16
`define FQT_OFF_ALT_LO 8'h17
`define FQT_OFF_ALT_HI 8'h18
`define FQT_OFF_SEC_LO 8'h19
`define FQT_OFF_SEC_HI 8'h1A
`define FQT_OFF_VLOG_MIN 8'h1B
`define FQT_OFF_VLOG_MAX 8'h1C
`define FQT_OFF_VPRG_MIN 8'h1D
`define FQT_OFF_VPRG_MAX 8'h1E
`define FQT_OFF_WP_TYP 8'h1F
`define FQT_OFF_BW_TYP 8'h20
`define FQT_OFF_BE_TYP 8'h21
`define FQT_OFF_CE_TYP 8'h22
`define FQT_OFF_WP_MAX 8'h23
`define FQT_OFF_BW_MAX 8'h24
`define FQT_OFF_BE_MAX 8'h25
`define FQT_OFF_CE_MAX 8'h26
`define FQT_OFF_CAP 8'h27
`define FQT_OFF_IF_LO 8'h28
`define FQT_OFF_IF_HI 8'h29
`define FQT_OFF_WBUF_LO 8'h2A
`define FQT_OFF_WBUF_HI 8'h2B
`define FQT_OFF_REGIONS 8'h2C
`define FQT_OFF_RGN_B0 8'h2D
`define FQT_OFF_RGN_B1 8'h2E
`define FQT_OFF_RGN_B2 8'h2F
`define FQT_OFF_RGN_B3 8'h30

// Field contents
`define FQT_SIG0 8'h51
`define FQT_SIG1 8'h52
`define FQT_SIG2 8'h59
`define FQT_EXT_PTR 8'h31
`define FQT_VLOG_MIN 8'h27
`define FQT_VLOG_MAX 8'h36
`define FQT_VPRG 8'h00
`define FQT_WP_TYP 8'h08
`define FQT_BW_TYP 8'h08
`define FQT_BE_TYP 8'h0A
`define FQT_CE_NONE 8'h00
`define FQT_MAX_FACTOR 8'h04
`define FQT_CAP_BASE 8'h16
`define FQT_IF_X8X16 8'h02
`define FQT_WBUF_EXP 8'h05
`define FQT_REGION_CNT 8'h01
`define FQT_RGN_SIZE_HI 8'h02
`define FQT_RGN_Y_32M 8'h1F
`define FQT_RGN_Y_64M 8'h3F
`define FQT_RGN_Y_128M 8'h7F
`define FQT_RGN_Y_256M 8'hFF

// Arbitrary value for the primary command set code
`define FQT_PRI_CODE 16'h00A5

// Address layout: 64 Kword blocks
`define FQT_BLOCKS 256
`define FQT_WOFF_W 16
`define FQT_BLK_W 8

`endif

// ===== core/fqt_pkg.sv
/*
  Types of the flash query table: read mode and the packed module state.
  Assumes fqt_cfg.svh sits beside it on the include path.
*/
`include "fqt_cfg.svh"

package fqt_pkg;

  typedef enum logic [0:0] {
    FQT_ARRAY = 1'b0,
    FQT_QUERY = 1'b1
  } fqt_mode_t;

  typedef struct packed {
    fqt_mode_t mode;
    logic [15:0] data;
    logic valid;
  } fqt_state_t;

endpackage

// ===== verification/fqt_host_model.sv
/*
  Host controller model: issues mode commands and single reads.
  Assumes the query table answers one cycle after each taken read.
*/
`timescale 1ns/1ps
`default_nettype none
module fqt_host_model (
  input wire logic core_clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output logic query_enter,
  output logic query_exit,
  output logic rd_req,
  output logic [24:0] rd_addr
);
  initial begin
    query_enter = 1'b0;
    query_exit = 1'b0;
    rd_req = 1'b0;
    rd_addr = 25'h0000000;
  end
  task automatic cmd(input logic en, input logic ex);
    @(posedge core_clk);
    #1;
    query_enter = en;
    query_exit = ex;
    @(posedge core_clk);
    #1;
    query_enter = 1'b0;
    query_exit = 1'b0;
  endtask
  task automatic rd(input logic [24:0] a, output logic [15:0] d,
                    output logic ok);
    int n;
    @(posedge core_clk);
    #1;
    rd_req = 1'b1;
    rd_addr = a;
    @(posedge core_clk);
    #1;
    rd_req = 1'b0;
    // Released address goes stale
    rd_addr = ~a;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    ok = (rd_valid === 1'b1);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for the query table, largest capacity.
  Assumes fqt_cfg.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fqt_cfg.svh"
module testbench;
  localparam logic [1:0] CAP = 2'h3;
  logic core_clk, rst, query_enter, query_exit, x8_mode, rd_req;
  logic query_active, rd_valid;
  logic [24:0] rd_addr;
  logic [15:0] array_data, rd_data, d;
  logic [255:0] block_locked;
  logic [15:0] pri = `FQT_PRI_CODE;
  logic [7:0] blks [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};
  int failures, check_count;

  fqt_query_table #(.CAP_SEL(CAP)) fqt_query_table_inst (
    .core_clk(core_clk), .rst(rst), .query_enter(query_enter),
    .query_exit(query_exit), .x8_mode(x8_mode), .rd_req(rd_req),
    .rd_addr(rd_addr), .array_data(array_data),
    .block_locked(block_locked), .query_active(query_active),
    .rd_data(rd_data), .rd_valid(rd_valid));
  fqt_host_model fqt_host_model_inst (
    .core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .query_enter(query_enter), .query_exit(query_exit),
    .rd_req(rd_req), .rd_addr(rd_addr));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic qrd(input logic [7:0] b, input logic [15:0] o,
                     input logic a0, output logic [15:0] v);
    logic ok;
    fqt_host_model_inst.rd(x8_mode ? {b, o, a0} : {1'b0, b, o}, v, ok);
    chk("rd_valid", {15'h0000, ok}, 16'h0001);
  endtask

  function automatic logic [7:0] qexp(input logic [7:0] o, input logic lk);
    case (o)
      8'h02: qexp = {7'h00, lk};
      8'h10: qexp = 8'h51;
      8'h11: qexp = 8'h52;
      8'h12: qexp = 8'h59;
      8'h13: qexp = pri[7:0];
      8'h14: qexp = pri[15:8];
      8'h15: qexp = 8'h31;
      8'h1B: qexp = 8'h27;
      8'h1C: qexp = 8'h36;
      8'h1F, 8'h20: qexp = 8'h08;
      8'h21: qexp = 8'h0A;
      8'h23, 8'h24, 8'h25: qexp = 8'h04;
      8'h27: qexp = 8'h16 + {6'h00, CAP};
      8'h28: qexp = 8'h02;
      8'h2A: qexp = 8'h05;
      8'h2C: qexp = 8'h01;
      8'h2D: qexp = 8'hFF;
      8'h30: qexp = 8'h02;
      default: qexp = 8'h00;
    endcase
  endfunction

  initial begin
    rst = 1'b1;
    x8_mode = 1'b0;
    array_data = 16'h5AC3;
    block_locked = '0;
    block_locked[1] = 1'b1;
    block_locked[3] = 1'b1;
    block_locked[255] = 1'b1;
    failures = 0;
    check_count = 0;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk("query_active", {15'h0000, query_active}, 16'h0000);
    qrd(8'h03, 16'h0010, 1'b0, d);
    chk("array read", d, 16'h5AC3);
    // Enter and exit together: enter wins
    fqt_host_model_inst.cmd(1'b1, 1'b1);
    chk("query_active", {15'h0000, query_active}, 16'h0001);
    for (int o = 0; o < 16'h34; o++) begin
      qrd(8'h03, o[15:0], 1'b0, d);
      chk("query byte", d, {8'h00, qexp(o[7:0], 1'b1)});
    end
    qrd(8'h03, 16'h0110, 1'b0, d);
    chk("query page", d, 16'h0000);
    x8_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (int a = 0; a < 2; a++) begin
        qrd(blks[i], 16'h0002, a[0], d);
        chk("lock state", d, {15'h0000, block_locked[blks[i]]});
      end
    end
    qrd(8'h01, 16'h0012, 1'b1, d);
    chk("x8 signature", d, 16'h0059);
    array_data = 16'h3CA5;
    fqt_host_model_inst.cmd(1'b0, 1'b1);
    chk("query_active", {15'h0000, query_active}, 16'h0000);
    qrd(8'h01, 16'h0002, 1'b0, d);
    chk("array read", d, 16'h3CA5);
    final_report;
  end

  initial begin
    #20000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
